//--- hdl/timed_pattern_output.sv
// timed pattern output unit: four 4-bit groups driven by timer compare matches
// assumes compare-match pulses and apb on pclk; standby request comes from a pin
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module timed_pattern_output
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer unit compare matches, one pulse per channel
    input  wire logic [3:0]  compare_match,
    // hardware standby request pin
    input  wire logic        hw_standby,
    // dma controller requests, one per group
    output logic      [3:0]  dma_request,
    // pattern pins shared with the two ports
    output logic      [15:0] pattern_pin_out,
    output logic      [15:0] pattern_pin_oe_n
);
    import pattern_output_pkg::*;

    // ==========================================================
    // decode helpers
    function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
        return (addr[31:18] == ADDR_TOP_ZERO) && (addr[17:2] == idx) && (addr[1:0] == ADDR_LANE);
    endfunction
    function automatic logic [TSEL_W-1:0] trig_sel(input logic [7:0] tc, input int g);
        return tc[g*TSEL_W +: TSEL_W];
    endfunction

    // ==========================================================
    // state
    logic [3:0]       mode_q,    mode_d;
    logic [7:0]       tc_q,      tc_d;
    logic [15:0]      en_q,      en_d;
    logic [15:0]      nd_q,      nd_d;
    logic [15:0]      oe_n_q,    oe_n_d;
    logic [15:0]      pd_q,      pd_d;
    logic [15:0]      pend_q,    pend_d;
    logic [CNT_W-1:0] cnt_q [GROUPS];
    logic [CNT_W-1:0] cnt_d [GROUPS];
    logic [3:0]       cm_q;
    logic [3:0]       dma_q,     dma_d;
    logic [31:0]      prdata_q,  prdata_d;
    logic             pready_q,  pready_d;
    logic             pslverr_q, pslverr_d;
    logic             stby_s1_q, stby_s2_q, stby_s3_q;
    logic             stby_q,    stby_d;
    logic [3:0]       grp_trig;
    logic             same_low;
    logic             same_high;
    logic             wr_en;
    logic [7:0]       wbyte;
    logic [7:0]       rdata;
    logic             unmapped;

    // ==========================================================
    // trigger selection per group
    always_comb
    begin
        for (int g = 0; g < GROUPS; g++)
        begin
            grp_trig[g] = cm_q[trig_sel(tc_q, g)];
        end
        same_low  = (trig_sel(tc_q, 0) == trig_sel(tc_q, 1));
        same_high = (trig_sel(tc_q, 2) == trig_sel(tc_q, 3));
        wr_en     = psel && penable && pready_q && pwrite;
        wbyte     = pwdata[7:0];
    end

    // ==========================================================
    // read mux
    always_comb
    begin
        rdata    = RST_ZERO;
        unmapped = 1'b0;
        if (reg_hit(paddr, IDX_PATTERN_MODE))
            rdata = {NIB_ONES, mode_q};
        else if (reg_hit(paddr, IDX_TRIGGER_CONTROL))
            rdata = tc_q;
        else if (reg_hit(paddr, IDX_ENABLE_HIGH))
            rdata = en_q[15:8];
        else if (reg_hit(paddr, IDX_ENABLE_LOW))
            rdata = en_q[7:0];
        else if (reg_hit(paddr, IDX_NEXT_HIGH))
            rdata = same_high ? nd_q[15:8] : {nd_q[15:12], NIB_ONES};
        else if (reg_hit(paddr, IDX_NEXT_HIGH_ALT))
            rdata = same_high ? BYTE_ONES : {NIB_ONES, nd_q[11:8]};
        else if (reg_hit(paddr, IDX_NEXT_LOW))
            rdata = same_low ? nd_q[7:0] : {nd_q[7:4], NIB_ONES};
        else if (reg_hit(paddr, IDX_NEXT_LOW_ALT))
            rdata = same_low ? BYTE_ONES : {NIB_ONES, nd_q[3:0]};
        else if (reg_hit(paddr, IDX_LOW_DIRECTION) || reg_hit(paddr, IDX_HIGH_DIRECTION))
            rdata = BYTE_ONES; // write-only
        else if (reg_hit(paddr, IDX_LOW_OUTPUT))
            rdata = pd_q[7:0];
        else if (reg_hit(paddr, IDX_HIGH_OUTPUT))
            rdata = pd_q[15:8];
        else
            unmapped = 1'b1;
    end

    // ==========================================================
    // apb handshake: one wait state, answer registered
    always_comb
    begin
        pready_d  = 1'b0;
        prdata_d  = RDATA_ZERO;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q)
        begin
            pready_d  = 1'b1;
            pslverr_d = unmapped;
            prdata_d  = pwrite ? RDATA_ZERO : {RDATA_PAD, rdata};
        end
    end

    // ==========================================================
    // standby synchroniser, change accepted when stages two and three agree
    always_comb
    begin
        stby_d = (stby_s2_q == stby_s3_q) ? stby_s2_q : stby_q;
    end

    // ==========================================================
    // configuration registers
    always_comb
    begin
        mode_d = mode_q;
        tc_d   = tc_q;
        en_d   = en_q;
        nd_d   = nd_q;
        oe_n_d = oe_n_q;
        if (wr_en)
        begin
            if (reg_hit(paddr, IDX_PATTERN_MODE))
                mode_d = wbyte[3:0];
            if (reg_hit(paddr, IDX_TRIGGER_CONTROL))
                tc_d = wbyte;
            if (reg_hit(paddr, IDX_ENABLE_HIGH))
                en_d[15:8] = wbyte;
            if (reg_hit(paddr, IDX_ENABLE_LOW))
                en_d[7:0] = wbyte;
            if (reg_hit(paddr, IDX_NEXT_HIGH))
            begin
                nd_d[15:12] = wbyte[7:4];
                if (same_high)
                    nd_d[11:8] = wbyte[3:0];
            end
            if (reg_hit(paddr, IDX_NEXT_HIGH_ALT) && !same_high)
                nd_d[11:8] = wbyte[3:0];
            if (reg_hit(paddr, IDX_NEXT_LOW))
            begin
                nd_d[7:4] = wbyte[7:4];
                if (same_low)
                    nd_d[3:0] = wbyte[3:0];
            end
            if (reg_hit(paddr, IDX_NEXT_LOW_ALT) && !same_low)
                nd_d[3:0] = wbyte[3:0];
            if (reg_hit(paddr, IDX_LOW_DIRECTION))
                oe_n_d[7:0] = ~wbyte;
            if (reg_hit(paddr, IDX_HIGH_DIRECTION))
                oe_n_d[15:8] = ~wbyte;
        end
        if (stby_q)
        begin
            en_d = RST_PINS;
            nd_d = RST_PINS;
        end
    end

    // ==========================================================
    // port data, group transfers and non-overlap margin
    always_comb
    begin
        pd_d   = pd_q;
        pend_d = pend_q;
        dma_d  = grp_trig;
        if (wr_en && reg_hit(paddr, IDX_LOW_OUTPUT))
            pd_d[7:0] = (wbyte & ~en_q[7:0]) | (pd_q[7:0] & en_q[7:0]);
        if (wr_en && reg_hit(paddr, IDX_HIGH_OUTPUT))
            pd_d[15:8] = (wbyte & ~en_q[15:8]) | (pd_q[15:8] & en_q[15:8]);
        for (int g = 0; g < GROUPS; g++)
        begin
            cnt_d[g] = cnt_q[g];
            if (cnt_q[g] != CNT_ZERO)
            begin
                cnt_d[g] = cnt_q[g] - CNT_ONE;
                if (cnt_q[g] == CNT_ONE)
                begin
                    // margin over: raise held-back bits still enabled
                    pd_d[g*NIBBLE_W +: NIBBLE_W] = pd_d[g*NIBBLE_W +: NIBBLE_W]
                        | (pend_q[g*NIBBLE_W +: NIBBLE_W] & en_q[g*NIBBLE_W +: NIBBLE_W]);
                    pend_d[g*NIBBLE_W +: NIBBLE_W] = NIB_ZERO;
                end
            end
            if (grp_trig[g])
            begin
                if (!mode_q[g])
                begin
                    // whole nibble at once, disabled bits hold
                    pd_d[g*NIBBLE_W +: NIBBLE_W] = (pd_d[g*NIBBLE_W +: NIBBLE_W] & ~en_q[g*NIBBLE_W +: NIBBLE_W])
                        | (nd_q[g*NIBBLE_W +: NIBBLE_W] & en_q[g*NIBBLE_W +: NIBBLE_W]);
                end
                else
                begin
                    // falling bits now, rising bits after the margin
                    pd_d[g*NIBBLE_W +: NIBBLE_W] = pd_d[g*NIBBLE_W +: NIBBLE_W]
                        & ~(en_q[g*NIBBLE_W +: NIBBLE_W] & ~nd_q[g*NIBBLE_W +: NIBBLE_W]);
                    pend_d[g*NIBBLE_W +: NIBBLE_W] = en_q[g*NIBBLE_W +: NIBBLE_W] & nd_q[g*NIBBLE_W +: NIBBLE_W]
                        & ~pd_d[g*NIBBLE_W +: NIBBLE_W];
                    cnt_d[g] = CNT_LOAD;
                end
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q    <= RST_MODE_LOW;
            tc_q      <= RST_TRIGGER;
            en_q      <= RST_PINS;
            nd_q      <= RST_PINS;
            oe_n_q    <= RST_OE_N;
            pd_q      <= RST_PINS;
            pend_q    <= RST_PINS;
            cm_q      <= NIB_ZERO;
            dma_q     <= NIB_ZERO;
            prdata_q  <= RDATA_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            stby_s1_q <= 1'b0;
            stby_s2_q <= 1'b0;
            stby_s3_q <= 1'b0;
            stby_q    <= 1'b0;
            cnt_q     <= '{default: CNT_ZERO};
        end
        else
        begin
            mode_q    <= mode_d;
            tc_q      <= tc_d;
            en_q      <= en_d;
            nd_q      <= nd_d;
            oe_n_q    <= oe_n_d;
            pd_q      <= pd_d;
            pend_q    <= pend_d;
            cm_q      <= compare_match;
            dma_q     <= dma_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            stby_s1_q <= hw_standby;
            stby_s2_q <= stby_s1_q;
            stby_s3_q <= stby_s2_q;
            stby_q    <= stby_d;
            cnt_q     <= cnt_d;
        end
    end

    // ==========================================================
    // outputs, low port on pins 7-0, high port on pins 15-8
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign dma_request      = dma_q;
    assign pattern_pin_out  = pd_q;
    assign pattern_pin_oe_n = oe_n_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_group0_copy: assert property (grp_trig[0] && !mode_q[0] |=>
        (pd_q[3:0] & $past(en_q[3:0])) == ($past(nd_q[3:0]) & $past(en_q[3:0])))
        else $error("group zero did not take next data");
    a_group2_together: assert property (grp_trig[2] && !mode_q[2] && !(wr_en && reg_hit(paddr, IDX_HIGH_OUTPUT))
        |=> pd_q[11:8] == (($past(nd_q[11:8]) & $past(en_q[11:8]))
        | ($past(pd_q[11:8]) & ~$past(en_q[11:8]))))
        else $error("group two bits did not update together");
    a_disabled_hold: assert property ((en_q == RST_PINS) && (pend_q == RST_PINS) && !wr_en |=> $stable(pd_q))
        else $error("pins moved with no enabled bits");
    a_readonly_bits: assert property (wr_en && reg_hit(paddr, IDX_LOW_OUTPUT) && (grp_trig[1:0] == 2'h0)
        && (pend_q[7:0] == RST_ZERO) |=> (pd_q[7:0] & $past(en_q[7:0])) == ($past(pd_q[7:0]) & $past(en_q[7:0])))
        else $error("write changed an enabled port bit");
    a_reserved_ones: assert property (psel && penable && !pready_q && !pwrite
        && reg_hit(paddr, IDX_NEXT_LOW_ALT) && same_low |=> prdata_q[7:0] == BYTE_ONES)
        else $error("reserved next data address not read as ones");
    a_high_split: assert property (psel && penable && !pready_q && !pwrite
        && reg_hit(paddr, IDX_NEXT_HIGH) && !same_high |=> prdata_q[3:0] == NIB_ONES)
        else $error("split high next data low nibble not ones");
    a_nonovl_margin: assert property (grp_trig[0] && mode_q[0] && !wr_en && (cnt_q[0] != CNT_ONE)
        |=> ((pd_q[3:0] & ~$past(pd_q[3:0]) & $past(en_q[3:0])) == NIB_ZERO))
        else $error("rising bit without margin in non-overlap mode");
    a_dma_pulse: assert property (dma_q == $past(grp_trig))
        else $error("dma request does not follow the group trigger");
    a_dir_write: assert property (wr_en && reg_hit(paddr, IDX_LOW_DIRECTION)
        |=> pattern_pin_oe_n[7:0] == ~$past(pwdata[7:0]))
        else $error("direction write not reflected on output enables");
    a_apb_wait: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb answer not after one wait state");

endmodule // timed_pattern_output

//--- hdl/pattern_output_pkg.sv
// constants shared by the timed pattern output unit
// assumes a 32-bit apb bus, word-aligned registers, one 100 mhz clock
package pattern_output_pkg;

    // ==========================================================
    // geometry
    localparam int GROUPS   = 4;
    localparam int NIBBLE_W = 4;
    localparam int PINS     = 16;
    localparam int BYTE_W   = 8;
    localparam int TSEL_W   = 2;
    localparam int CNT_W    = 4;

    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_PATTERN_MODE    = 16'hffa0;
    localparam logic [15:0] IDX_TRIGGER_CONTROL = 16'hffa1;
    localparam logic [15:0] IDX_ENABLE_HIGH     = 16'hffa2;
    localparam logic [15:0] IDX_ENABLE_LOW      = 16'hffa3;
    localparam logic [15:0] IDX_NEXT_HIGH       = 16'hffa4;
    localparam logic [15:0] IDX_NEXT_LOW        = 16'hffa5;
    localparam logic [15:0] IDX_NEXT_HIGH_ALT   = 16'hffa6;
    localparam logic [15:0] IDX_NEXT_LOW_ALT    = 16'hffa7;
    localparam logic [15:0] IDX_LOW_DIRECTION   = 16'hffd1;
    localparam logic [15:0] IDX_LOW_OUTPUT      = 16'hffd3;
    localparam logic [15:0] IDX_HIGH_DIRECTION  = 16'hffd4;
    localparam logic [15:0] IDX_HIGH_OUTPUT     = 16'hffd6;

    // ==========================================================
    // reset values and fill patterns
    localparam logic [7:0]  RST_MODE      = 8'hf0;
    localparam logic [7:0]  RST_TRIGGER   = 8'hff;
    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [3:0]  RST_MODE_LOW  = 4'h0;
    localparam logic [15:0] RST_OE_N      = 16'hffff;
    localparam logic [15:0] RST_PINS      = 16'h0000;
    localparam logic [3:0]  NIB_ONES      = 4'hf;
    localparam logic [3:0]  NIB_ZERO      = 4'h0;
    localparam logic [7:0]  BYTE_ONES     = 8'hff;
    localparam logic [23:0] RDATA_PAD     = 24'h000000;
    localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
    localparam logic [13:0] ADDR_TOP_ZERO = 14'h0000;
    localparam logic [1:0]  ADDR_LANE     = 2'h0;

    // ==========================================================
    // non-overlap margin between falling and rising edges
    localparam int CLK_PERIOD_NS    = 10;
    localparam int NONOVL_MARGIN_NS = 50;
    localparam int NONOVL_CYCLES    = (NONOVL_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(NONOVL_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

endpackage

//--- sim/timer_dma_model.sv
// partner model: timer compare-match source and dma request counter
// assumes it shares pclk with the pattern unit and is driven by the bench
`timescale 1ns/1ps

module timer_dma_model
(
    // clock
    input  wire logic       pclk,
    // link to the pattern unit
    output logic      [3:0] compare_match,
    input  wire logic [3:0] dma_request
);
    int dma_cnt [4];

    // quiet channels at time zero
    initial
    begin
        compare_match = 4'h0;
        foreach (dma_cnt[g])
            dma_cnt[g] = 0;
    end

    // one-cycle compare-match pulse on one channel, launched after an edge
    task automatic strike(input int ch);
        @(posedge pclk);
        compare_match <= 4'(1 << ch);
        @(posedge pclk);
        compare_match <= 4'h0;
    endtask

    // count dma starts per group, as a dma controller would
    always @(posedge pclk)
    begin
        for (int g = 0; g < 4; g++)
            if (dma_request[g] === 1'b1)
                dma_cnt[g]++;
    end
endmodule // timer_dma_model

//--- sim/timed_pattern_output_test.sv
// self-checking bench for the timed pattern output unit
// assumes the design package and the timer/dma partner model are compiled first
`timescale 1ns/1ps

module timed_pattern_output_test;
    import pattern_output_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  compare_match, dma_request;
    logic [15:0] pattern_pin_out, pattern_pin_oe_n;
    logic        err;
    int          err_total, n_tests;

    timed_pattern_output dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compare_match(compare_match), .hw_standby(hw_standby),
        .dma_request(dma_request), .pattern_pin_out(pattern_pin_out),
        .pattern_pin_oe_n(pattern_pin_oe_n));

    timer_dma_model tlm (.pclk(pclk), .compare_match(compare_match), .dma_request(dma_request));

    // ==========================================================
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // report helpers
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ==========================================================
    // apb master: setup, access, hold until pready sampled high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {14'h0000, idx, 2'h0};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_total++;
            wrap_up();
        end
    endtask

    task automatic rdchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, {24'h000000, exp}, rd);
    endtask

    // pins two edges after the compare-match edge
    task automatic strike_chk(input int ch, input logic [15:0] exp);
        tlm.strike(ch);
        repeat (2) @(posedge pclk);
        #1 chk("pins", exp, pattern_pin_out);
    endtask

    // ==========================================================
    // scenarios
    task automatic sc_reset();
        logic [15:0] idx [10] = '{16'hffa0, 16'hffa1, 16'hffa2, 16'hffa3, 16'hffa4,
                                  16'hffa5, 16'hffa6, 16'hffa7, 16'hffd3, 16'hffd6};
        logic [7:0]  exp [10] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
        chk("oe_n", 32'h0000ffff, {16'h0000, pattern_pin_oe_n});
        for (int i = 0; i < 10; i++)
            rdchk("reset reg", idx[i], exp[i]);
        apb(1'b1, 16'hffa6, 8'h00);
        rdchk("reserved", 16'hffa6, 8'hff);
        apb(1'b0, 16'hffb0, 8'h00);
        chk("slverr", 32'h1, {31'h0, err});
    endtask

    task automatic sc_same_trigger();
        apb(1'b1, 16'hffd1, 8'hff);
        apb(1'b1, 16'hffd4, 8'h0f);
        #1 chk("oe_n", 32'h0000f000, {16'h0000, pattern_pin_oe_n});
        apb(1'b1, 16'hffa3, 8'h0f);
        apb(1'b1, 16'hffa5, 8'ha5);
        strike_chk(3, 16'h0005);
        chk("dma", 32'h1, 32'(tlm.dma_cnt[0]));
        apb(1'b1, 16'hffd3, 8'hff);
        rdchk("port low", 16'hffd3, 8'hf5);
    endtask

    task automatic sc_split_trigger();
        apb(1'b1, 16'hffa1, 8'hf4);
        apb(1'b1, 16'hffa3, 8'hff);
        apb(1'b1, 16'hffa5, 8'h3c);
        rdchk("next grp1", 16'hffa5, 8'h3f);
        apb(1'b1, 16'hffa7, 8'h96);
        rdchk("next grp0", 16'hffa7, 8'hf6);
        strike_chk(1, 16'h0035);
        strike_chk(0, 16'h0036);
    endtask

    task automatic sc_high_split();
        apb(1'b1, 16'hffa1, 8'h24);
        apb(1'b1, 16'hffa4, 8'h7e);
        rdchk("next grp3", 16'hffa4, 8'h7f);
        apb(1'b1, 16'hffa6, 8'h21);
        rdchk("next grp2", 16'hffa6, 8'hf1);
        apb(1'b1, 16'hffa2, 8'h0f);
        strike_chk(2, 16'h0136);
    endtask

    task automatic sc_nonoverlap();
        apb(1'b1, 16'hffa0, 8'hf1);
        apb(1'b1, 16'hffa7, 8'h09);
        tlm.strike(0);
        repeat (2) @(posedge pclk);
        #1 chk("fall first", 32'h30, {24'h0, pattern_pin_out[7:0]});
        repeat (3) @(posedge pclk);
        #1 chk("still held", 32'h30, {24'h0, pattern_pin_out[7:0]});
        @(posedge pclk);
        #1 chk("rise later", 32'h39, {24'h0, pattern_pin_out[7:0]});
        chk("dma grp0", 32'h3, 32'(tlm.dma_cnt[0]));
        chk("dma grp1", 32'h2, 32'(tlm.dma_cnt[1]));
    endtask

    task automatic sc_standby();
        @(posedge pclk);
        hw_standby <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b1, 16'hffa3, 8'hff);
        rdchk("enable low", 16'hffa3, 8'h00);
        rdchk("next grp1", 16'hffa5, 8'h0f);
        rdchk("mode kept", 16'hffa0, 8'hf1);
        @(posedge pclk);
        hw_standby <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        err_total  = 0;
        n_tests    = 0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 32'h00000000;
        pwdata     = 32'h00000000;
        hw_standby = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset();
        sc_same_trigger();
        sc_split_trigger();
        sc_high_split();
        sc_nonoverlap();
        sc_standby();
        wrap_up();
    end
endmodule // timed_pattern_output_test
